// *** design/cras_defines.vh ***
// Constants for the register-to-register ALU and shift datapath.
// Assumes a 16-bit word, eight general registers, register 7 as program counter.
`ifndef CRAS_DEFINES_VH
`define CRAS_DEFINES_VH

`define CRAS_MAJ_SINGLE   4'h0
`define CRAS_MAJ_SHIFT    4'h1
`define CRAS_MAJ_MOVE     4'h2
`define CRAS_MAJ_ADD      4'h3
`define CRAS_MAJ_SUB      4'h4
`define CRAS_MAJ_CMP      4'h5
`define CRAS_MAJ_AND      4'h6
`define CRAS_MAJ_XOR      4'h7

`define CRAS_SUB_INC      3'h1
`define CRAS_SUB_DEC      3'h2
`define CRAS_SUB_COM      3'h3
`define CRAS_SUB_NEG      3'h4
`define CRAS_SUB_ADC      3'h5

`define CRAS_SH_SWAP      3'h0
`define CRAS_SH_SLL       3'h1
`define CRAS_SH_RLC       3'h2
`define CRAS_SH_SHIFT_LEFT_INTO_CARRY      3'h3
`define CRAS_SH_SLR       3'h4
`define CRAS_SH_SAR       3'h5

`define CRAS_REG_PC       3'h7
`define CRAS_REG_SP       3'h6
`define CRAS_SIGN_BIT     15
`define CRAS_RSIGN_BIT    7

`define CRAS_CYC_BASE     4'h6
`define CRAS_CYC_JUMP     4'h7
`define CRAS_CYC_EXTRA    4'h1
`define CRAS_CYC_SHIFT2   4'h8
`define CRAS_CNT_LAST     4'h2

`endif

// *** design/cras_regfile.v ***
// Eight-word general register file, two read ports and one write port.
// Assumes writes are issued by the datapath on the same clock.
`timescale 1ns/1ps
module cras_regfile #(
    parameter WIDTH = 16,
    parameter DEPTH = 8
)
(
    input  wire             i_clk,
    input  wire             i_srst,
    input  wire [2:0]       i_rd_a,
    input  wire [2:0]       i_rd_b,
    input  wire             i_we,
    input  wire [2:0]       i_wa,
    input  wire [WIDTH-1:0] i_wd,
    output wire [WIDTH-1:0] o_qa,
    output wire [WIDTH-1:0] o_qb
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    integer         k;

    assign o_qa = mem_reg[i_rd_a];
    assign o_qb = mem_reg[i_rd_b];

    always @(posedge i_clk)
    begin
        if (i_srst)
        begin
            for (k = 0; k < DEPTH; k = k + 1)
                mem_reg[k] <= {WIDTH{1'b0}};
        end
        else if (i_we)
            mem_reg[i_wa] <= i_wd;
    end
endmodule

// *** design/cras_shifter.v ***
// Combinational shift, rotate and byte-swap unit, one or two steps.
// Assumes flags in are the current carry and range flags.
`timescale 1ns/1ps
`include "cras_defines.vh"
module cras_shifter
(
    input  wire [2:0]  i_op,
    input  wire        i_double,
    input  wire [15:0] i_val,
    input  wire        i_carry,
    input  wire        i_ovf,
    output reg  [15:0] o_res,
    output reg         o_carry,
    output reg         o_ovf,
    output reg         o_c_upd,
    output reg         o_v_upd,
    output reg         o_right
);
    always @*
    begin
        o_res   = i_val;
        o_carry = i_carry;
        o_ovf   = i_ovf;
        o_c_upd = 1'b0;
        o_v_upd = 1'b0;
        o_right = 1'b0;
        case (i_op)
            `CRAS_SH_SWAP:
                // A double swap restores the word; only the timing differs
                o_res = i_double ? i_val : {i_val[7:0], i_val[15:8]};
            `CRAS_SH_SLL:
                o_res = i_double ? {i_val[13:0], 2'b00} : {i_val[14:0], 1'b0};
            `CRAS_SH_RLC:
            begin
                o_c_upd = 1'b1;
                o_v_upd = i_double;
                if (i_double)
                begin
                    // Eighteen-bit rotate: the top data bit lands in carry, the next in range flag
                    o_res   = {i_val[13:0], i_carry, i_ovf};
                    o_carry = i_val[15];
                    o_ovf   = i_val[14];
                end
                else
                begin
                    o_res   = {i_val[14:0], i_carry};
                    o_carry = i_val[15];
                end
            end
            `CRAS_SH_SHIFT_LEFT_INTO_CARRY:
            begin
                o_c_upd = 1'b1;
                o_v_upd = i_double;
                if (i_double)
                begin
                    o_res   = {i_val[13:0], 2'b00};
                    o_carry = i_val[15];
                    o_ovf   = i_val[14];
                end
                else
                begin
                    o_res   = {i_val[14:0], 1'b0};
                    o_carry = i_val[15];
                end
            end
            `CRAS_SH_SLR:
            begin
                o_right = 1'b1;
                o_res   = i_double ? {2'b00, i_val[15:2]} : {1'b0, i_val[15:1]};
            end
            `CRAS_SH_SAR:
            begin
                o_right = 1'b1;
                o_res   = i_double ? {{2{i_val[15]}}, i_val[15:2]} : {i_val[15], i_val[15:1]};
            end
            default:
                o_res = i_val;
        endcase
    end
endmodule

// *** design/cras_alu.v ***
// Register-to-register ALU datapath: move, test, jump, arithmetic, logic and shift.
// Assumes the sequencer presents a decoded instruction with a one-cycle start pulse
// and waits for o_done before issuing the next one.
`timescale 1ns/1ps
`include "cras_defines.vh"
// Function
// - Copy moves source into a different destination in 6 cycles, sign and zero only.
// - Copy or test with destination register 6 or 7 takes one extra cycle.
// - Test with equal fields sets sign and zero, leaves registers unchanged.
// - Jump copies source into register 7 in 7 cycles, sign and zero.
// - Sum adds source to destination, stores it, updates all four flags, 6 cycles.
// - Subtract takes source from destination, stores it, all four flags, 6 cycles.
// - Compare subtracts for flags only and writes no register.
// - AND stores the bitwise product, sign and zero only, 6 cycles.
// - Exclusive-OR stores the result, sign and zero only.
// - Exclusive-OR of a register with itself zeroes it in 6 cycles.
// - Increment adds one to the register, sign and zero only.
// - Decrement subtracts one from the register, sign and zero only.
// - Negate stores the two's complement, all four flags.
// - Add-carry adds the carry flag to the register, all four flags.
// - Right shifts take the sign flag from result bit 7.
// - Byte swap exchanges bytes in 6 cycles, double swap restores in 8.
// - Logical left shift by one or two, zero fill, sign and zero.
// - Rotate left through carry, or carry and range flag for two steps.
// - Left shift into carry, or carry and range flag for two steps.
// - Logical right shift by one or two, zero fill, sign and zero.
// - Arithmetic right shift by one or two, sign copied, sign and zero.
module cras_alu #(
    parameter WIDTH = 16
)
(
    input  wire             i_clk,
    input  wire             i_srst,
    input  wire             i_start,
    input  wire [3:0]       i_major,
    input  wire [2:0]       i_source_reg_field,
    input  wire [2:0]       i_dest_reg_field,
    output reg              o_busy,
    output reg              o_done,
    output reg  [3:0]       o_cycles,
    output reg              o_sign,
    output reg              o_zero,
    output reg              o_carry,
    output reg              o_signed_range_flag,
    output reg  [WIDTH-1:0] o_result,
    output reg              o_illegal
);
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_DONE = 2'b10;

    reg  [1:0]       state_reg;
    reg  [1:0]       state_next;
    reg  [3:0]       count_reg;
    reg  [3:0]       major_reg;
    reg  [2:0]       src_reg;
    reg  [2:0]       dst_reg;
    reg              dbl_reg;

    wire [WIDTH-1:0] qa;
    wire [WIDTH-1:0] qb;
    wire [15:0]      sh_res;
    wire             sh_c;
    wire             sh_v;
    wire             sh_cu;
    wire             sh_vu;
    wire             sh_right;

    reg  [WIDTH-1:0] res;
    reg              we;
    reg              c_new;
    reg              v_new;
    reg              c_upd;
    reg              v_upd;
    reg              sign_new;
    reg  [3:0]       cyc;
    reg              bad;

    // Carry is the unsigned carry out; subtract carry means no borrow
    function [WIDTH+1:0] add_flags;
        input [WIDTH-1:0] a;
        input [WIDTH-1:0] b;
        input             cin;
        reg   [WIDTH:0]   s;
        begin
            s = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
            add_flags = {s[WIDTH], (a[WIDTH-1] == b[WIDTH-1]) && (s[WIDTH-1] != a[WIDTH-1]),
                         s[WIDTH-1:0]};
        end
    endfunction

    reg [WIDTH+1:0] sum;

    // Register fields are latched at start; the file is written only in ST_DONE, so it holds still during the count
    cras_regfile #(
        .WIDTH (WIDTH),
        .DEPTH (8)
    ) u_rf (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_rd_a (src_reg),
        .i_rd_b (dst_reg),
        .i_we   (we),
        .i_wa   (dst_reg),
        .i_wd   (res),
        .o_qa   (qa),
        .o_qb   (qb)
    );

    cras_shifter u_sh (
        .i_op     (src_reg),
        .i_double (dbl_reg),
        .i_val    (qb),
        .i_carry  (o_carry),
        .i_ovf    (o_signed_range_flag),
        .o_res    (sh_res),
        .o_carry  (sh_c),
        .o_ovf    (sh_v),
        .o_c_upd  (sh_cu),
        .o_v_upd  (sh_vu),
        .o_right  (sh_right)
    );

    // Evaluation happens in ST_DONE on latched fields; shift target is dst[1:0]
    always @*
    begin
        res      = {WIDTH{1'b0}};
        we       = 1'b0;
        c_new    = o_carry;
        v_new    = o_signed_range_flag;
        c_upd    = 1'b0;
        v_upd    = 1'b0;
        sum      = {(WIDTH+2){1'b0}};
        sign_new = 1'b0;
        if (state_reg == ST_DONE)
        begin
            case (major_reg)
                `CRAS_MAJ_MOVE:
                begin
                    res = qa;
                    we  = (src_reg != dst_reg);
                end
                `CRAS_MAJ_ADD:
                begin
                    sum = add_flags(qb, qa, 1'b0);
                    res = sum[WIDTH-1:0];
                    we  = 1'b1;
                    c_upd = 1'b1;
                    v_upd = 1'b1;
                end
                `CRAS_MAJ_SUB, `CRAS_MAJ_CMP:
                begin
                    sum = add_flags(qb, ~qa, 1'b1);
                    res = sum[WIDTH-1:0];
                    we  = (major_reg == `CRAS_MAJ_SUB);
                    c_upd = 1'b1;
                    v_upd = 1'b1;
                end
                `CRAS_MAJ_AND:
                begin
                    res = qa & qb;
                    we  = 1'b1;
                end
                `CRAS_MAJ_XOR:
                begin
                    res = qa ^ qb;
                    we  = 1'b1;
                end
                `CRAS_MAJ_SINGLE:
                begin
                    we = 1'b1;
                    case (src_reg)
                        `CRAS_SUB_INC:
                        begin
                            sum = add_flags(qb, {WIDTH{1'b0}}, 1'b1);
                            res = sum[WIDTH-1:0];
                        end
                        `CRAS_SUB_DEC:
                        begin
                            sum = add_flags(qb, {WIDTH{1'b1}}, 1'b0);
                            res = sum[WIDTH-1:0];
                        end
                        `CRAS_SUB_COM:
                            res = ~qb;
                        `CRAS_SUB_NEG:
                        begin
                            sum = add_flags(~qb, {WIDTH{1'b0}}, 1'b1);
                            res = sum[WIDTH-1:0];
                            c_upd = 1'b1;
                            v_upd = 1'b1;
                        end
                        `CRAS_SUB_ADC:
                        begin
                            sum = add_flags(qb, {WIDTH{1'b0}}, o_carry);
                            res = sum[WIDTH-1:0];
                            c_upd = 1'b1;
                            v_upd = 1'b1;
                        end
                        default:
                        begin
                            res = qb;
                            we  = 1'b0;
                        end
                    endcase
                end
                `CRAS_MAJ_SHIFT:
                begin
                    res   = sh_res;
                    we    = 1'b1;
                    c_new = sh_c;
                    v_new = sh_v;
                    c_upd = sh_cu;
                    v_upd = sh_vu;
                end
                default:
                    res = qb;
            endcase
            if (c_upd && (major_reg != `CRAS_MAJ_SHIFT))
            begin
                c_new = sum[WIDTH+1];
                v_new = sum[WIDTH];
            end
            if ((major_reg == `CRAS_MAJ_SHIFT) && sh_right)
                sign_new = res[`CRAS_RSIGN_BIT];
            else if ((major_reg == `CRAS_MAJ_SHIFT) && (src_reg == `CRAS_SH_SWAP))
                sign_new = res[`CRAS_RSIGN_BIT];
            else
                sign_new = res[`CRAS_SIGN_BIT];
        end
    end

    // Cycle count and legality decoded from the incoming instruction
    always @*
    begin
        cyc = `CRAS_CYC_BASE;
        bad = 1'b0;
        case (i_major)
            `CRAS_MAJ_MOVE:
                if (i_dest_reg_field == `CRAS_REG_PC && i_source_reg_field != `CRAS_REG_PC)
                    cyc = `CRAS_CYC_JUMP;
                else if (i_dest_reg_field == `CRAS_REG_SP || i_dest_reg_field == `CRAS_REG_PC)
                    cyc = `CRAS_CYC_BASE + `CRAS_CYC_EXTRA;
                else
                    cyc = `CRAS_CYC_BASE;
            `CRAS_MAJ_SHIFT:
            begin
                cyc = i_dest_reg_field[2] ? `CRAS_CYC_SHIFT2 : `CRAS_CYC_BASE;
                bad = (i_source_reg_field > `CRAS_SH_SAR);
            end
            `CRAS_MAJ_SINGLE:
                bad = (i_source_reg_field < `CRAS_SUB_INC) || (i_source_reg_field > `CRAS_SUB_ADC);
            `CRAS_MAJ_ADD, `CRAS_MAJ_SUB, `CRAS_MAJ_CMP, `CRAS_MAJ_AND, `CRAS_MAJ_XOR:
                cyc = `CRAS_CYC_BASE;
            default:
                bad = 1'b1;
        endcase
    end

    always @*
    begin
        case (state_reg)
            ST_IDLE:
                state_next = (i_start && !bad) ? ST_WAIT : ST_IDLE;
            ST_WAIT:
                state_next = (count_reg == `CRAS_CNT_LAST) ? ST_DONE : ST_WAIT;
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // Start is taken in cycle 0; the answer lands after the documented cycle count
    always @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_reg           <= ST_IDLE;
            count_reg           <= 4'h0;
            major_reg           <= 4'h0;
            src_reg             <= 3'h0;
            dst_reg             <= 3'h0;
            dbl_reg             <= 1'b0;
            o_busy              <= 1'b0;
            o_done              <= 1'b0;
            o_cycles            <= 4'h0;
            o_sign              <= 1'b0;
            o_zero              <= 1'b0;
            o_carry             <= 1'b0;
            o_signed_range_flag <= 1'b0;
            o_result            <= {WIDTH{1'b0}};
            o_illegal           <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            o_done    <= 1'b0;
            o_illegal <= i_start && (state_reg == ST_IDLE) && bad;
            case (state_reg)
                ST_IDLE:
                    if (i_start && !bad)
                    begin
                        major_reg <= i_major;
                        src_reg   <= i_source_reg_field;
                        // Shift forms carry their target in the low two bits
                        dst_reg   <= i_dest_reg_field;
                        // Double-step bit kept apart, since dst_reg drops it before evaluation
                        dbl_reg   <= i_dest_reg_field[2];
                        count_reg <= cyc - 4'h1;
                        o_cycles  <= cyc;
                        o_busy    <= 1'b1;
                    end
                ST_WAIT:
                begin
                    count_reg <= count_reg - 4'h1;
                    if (major_reg == `CRAS_MAJ_SHIFT && count_reg == `CRAS_CNT_LAST)
                        dst_reg <= {1'b0, dst_reg[1:0]};
                end
                ST_DONE:
                begin
                    o_busy   <= 1'b0;
                    o_done   <= 1'b1;
                    o_result <= res;
                    o_sign   <= sign_new;
                    o_zero   <= (res == {WIDTH{1'b0}});
                    if (c_upd)
                        o_carry <= c_new;
                    if (v_upd)
                        o_signed_range_flag <= v_new;
                end
                default:
                    o_busy <= 1'b0;
            endcase
        end
    end
endmodule

// *** tb/cras_alu_chk.sv ***
// Concurrent checks on the ALU datapath ports, bound to cras_alu.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module cras_alu_chk #(
    parameter WIDTH = 16
)
(
    input wire             i_clk,
    input wire             i_srst,
    input wire             i_start,
    input wire [3:0]       i_major,
    input wire [2:0]       i_source_reg_field,
    input wire [2:0]       i_dest_reg_field,
    input wire             o_busy,
    input wire             o_done,
    input wire [3:0]       o_cycles,
    input wire             o_sign,
    input wire             o_zero,
    input wire             o_carry,
    input wire             o_signed_range_flag,
    input wire [WIDTH-1:0] o_result,
    input wire             o_illegal
);
    wire [2:0] sub = i_source_reg_field;
    wire       legal = (i_major < 4'h8) && !((i_major == 4'h0) && ((sub == 3'h0) || (sub > 3'h5)))
                       && !((i_major == 4'h1) && (sub > 3'h5));
    wire       take = i_start && !o_busy && legal;
    reg  [3:0] cnt_reg;
    reg        low_reg;
    reg        keep_reg;
    reg        c_reg;
    reg        v_reg;
    // Counts cycles from the taking edge so the done pulse can be tied to o_cycles
    always @(posedge i_clk)
    begin
        if (i_srst)
        begin
            cnt_reg  <= 4'h0;
            low_reg  <= 1'b0;
            keep_reg <= 1'b0;
        end
        else if (take)
        begin
            cnt_reg  <= 4'h1;
            low_reg  <= (i_major == 4'h1) && ((sub == 3'h0) || (sub == 3'h4) || (sub == 3'h5));
            keep_reg <= (i_major == 4'h2) || (i_major == 4'h6) || (i_major == 4'h7)
                        || ((i_major == 4'h0) && (sub < 3'h4))
                        || ((i_major == 4'h1) && (sub != 3'h2) && (sub != 3'h3));
            c_reg    <= o_carry;
            v_reg    <= o_signed_range_flag;
        end
        else if (o_busy)
            cnt_reg <= cnt_reg + 4'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    done_count_a: assert property (o_done |-> cnt_reg == o_cycles)
        else $error("done pulse not at the announced cycle count");
    done_pulse_a: assert property (o_done |-> !o_busy ##1 !o_done)
        else $error("done not a single pulse with busy low");
    take_busy_a: assert property (take |=> o_busy && !o_done && !o_illegal)
        else $error("accepted request did not raise busy");
    refuse_code_a: assert property (i_start && !o_busy && !legal |=> o_illegal && !o_busy)
        else $error("undecodable opcode not refused");
    move_long_a: assert property (take && i_major == 4'h2 && i_dest_reg_field[2:1] == 2'h3 |=> o_cycles == 4'h7)
        else $error("move to register 6 or 7 not seven cycles");
    move_base_a: assert property (take && i_major == 4'h2 && i_dest_reg_field < 3'h6 |=> o_cycles == 4'h6)
        else $error("move or test of low register not six cycles");
    base_len_a: assert property (take && (i_major > 4'h2 || (i_major == 4'h1 && !i_dest_reg_field[2]))
        |=> o_cycles == 4'h6)
        else $error("single step operation not six cycles");
    double_len_a: assert property (take && i_major == 4'h1 && i_dest_reg_field[2] |=> o_cycles == 4'h8)
        else $error("double step shift not eight cycles");
    zero_flag_a: assert property (o_done |-> o_zero == (o_result == 16'h0000))
        else $error("zero flag disagrees with result");
    sign_flag_a: assert property (o_done |-> o_sign == (low_reg ? o_result[7] : o_result[15]))
        else $error("sign flag taken from wrong bit");
    flags_kept_a: assert property (o_done && keep_reg |-> o_carry == c_reg && o_signed_range_flag == v_reg)
        else $error("carry or range flag changed by a sign and zero operation");
endmodule
bind cras_alu cras_alu_chk #(.WIDTH(WIDTH)) u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_start(i_start),
    .i_major(i_major), .i_source_reg_field(i_source_reg_field), .i_dest_reg_field(i_dest_reg_field),
    .o_busy(o_busy), .o_done(o_done), .o_cycles(o_cycles), .o_sign(o_sign), .o_zero(o_zero),
    .o_carry(o_carry), .o_signed_range_flag(o_signed_range_flag), .o_result(o_result), .o_illegal(o_illegal));

// *** tb/cras_seq_model.sv ***
// Instruction sequencer stand-in: presents one decoded instruction per call.
// Assumes the caller waits for completion before the next regular request.
`timescale 1ns/1ps
module cras_seq_model
(
    input  wire       i_clk,
    output reg        o_start,
    output reg  [3:0] o_major,
    output reg  [2:0] o_src,
    output reg  [2:0] o_dst
);
    initial
    begin
        o_start = 1'b0;
        o_major = 4'h0;
        o_src   = 3'h0;
        o_dst   = 3'h0;
    end
    // Gap models a slow sequencer; fields are held until the next request
    task issue(input [3:0] m, input [2:0] s, input [2:0] d, input integer gap);
        repeat (gap + 1) @(negedge i_clk);
        o_start = 1'b1;
        o_major = m;
        o_src   = s;
        o_dst   = d;
        @(negedge i_clk);
        o_start = 1'b0;
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the ALU datapath with a reference register model.
// Assumes all eight registers and flags are zero after reset.
`timescale 1ns/1ps
module testbench;
    reg         i_clk;
    reg         i_srst;
    wire        start;
    wire [3:0]  major;
    wire [2:0]  src;
    wire [2:0]  dst;
    wire        busy, done, sign, zero, carry, ovf, illegal;
    wire [3:0]  cycles;
    wire [15:0] result;
    integer     errors;
    integer     checked;
    integer     i;
    reg  [15:0] rf [0:7];
    reg         fs, fz, fc, fv;
    reg  [15:0] er;
    reg  [3:0]  ec;

    cras_alu #(.WIDTH(16)) DUT (.i_clk(i_clk), .i_srst(i_srst), .i_start(start), .i_major(major),
        .i_source_reg_field(src), .i_dest_reg_field(dst), .o_busy(busy), .o_done(done), .o_cycles(cycles),
        .o_sign(sign), .o_zero(zero), .o_carry(carry), .o_signed_range_flag(ovf), .o_result(result),
        .o_illegal(illegal));
    cras_seq_model seq (.i_clk(i_clk), .o_start(start), .o_major(major), .o_src(src), .o_dst(dst));

    always #10 i_clk = ~i_clk;

    task check(input string name, input [15:0] seen, input [15:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Reference behaviour, applied before the request is issued
    task model(input [3:0] m, input [2:0] s, input [2:0] d);
        reg [16:0] t;
        reg [15:0] a, b, r;
        reg        w, b7;
        reg [2:0]  dr;
        a = rf[s]; b = rf[d]; r = b; w = 1'b1; b7 = 1'b0; dr = d; ec = 4'h6;
        case (m)
            4'h0: case (s)
                3'h1: r = b + 16'h0001;
                3'h2: r = b - 16'h0001;
                3'h3: r = ~b;
                3'h4: begin r = 16'h0000 - b; fc = (b == 16'h0000); fv = (b == 16'h8000); end
                3'h5: begin t = b + fc; r = t[15:0]; fv = (b == 16'h7fff) && fc; fc = t[16]; end
            endcase
            4'h1:
            begin
                dr = {1'b0, d[1:0]}; b = rf[dr]; ec = d[2] ? 4'h8 : 4'h6;
                b7 = (s == 3'h0) || (s == 3'h4) || (s == 3'h5);
                case (s)
                    3'h0: r = d[2] ? b : {b[7:0], b[15:8]};
                    3'h1: r = d[2] ? {b[13:0], 2'h0} : {b[14:0], 1'b0};
                    3'h4: r = d[2] ? {2'h0, b[15:2]} : {1'b0, b[15:1]};
                    3'h5: r = d[2] ? {{2{b[15]}}, b[15:2]} : {b[15], b[15:1]};
                    default:
                    begin
                        r = d[2] ? {b[13:0], (s == 3'h2) & fc, (s == 3'h2) & fv} : {b[14:0], (s == 3'h2) & fc};
                        if (d[2]) fv = b[14];
                        fc = b[15];
                    end
                endcase
            end
            4'h2: begin r = a; if (d >= 3'h6) ec = 4'h7; w = (s != d); end
            4'h3: begin t = b + a; r = t[15:0]; fc = t[16]; fv = (a[15] == b[15]) && (r[15] != b[15]); end
            4'h6: r = b & a;
            4'h7: r = b ^ a;
            default:
            begin
                t = {1'b0, b} - a; r = t[15:0]; fc = !t[16]; w = (m == 4'h4);
                fv = (a[15] != b[15]) && (r[15] != b[15]);
            end
        endcase
        if (w) rf[dr] = r;
        er = r; fz = (r == 16'h0000); fs = b7 ? r[7] : r[15];
    endtask

    task wait_done(input integer k0);
        integer k;
        // The start cycle counts as the first of the instruction
        k = k0 + 1;
        while (done !== 1'b1 && k < 20)
        begin
            @(posedge i_clk); #1;
            k = k + 1;
        end
        check("latency", k[15:0], {12'h0, ec});
        check("cycles", {12'h0, cycles}, {12'h0, ec});
        check("result", result, er);
        check("flags", {12'h0, sign, zero, carry, ovf}, {12'h0, fs, fz, fc, fv});
    endtask

    task exec(input [3:0] m, input [2:0] s, input [2:0] d, input integer gap);
        model(m, s, d);
        seq.issue(m, s, d, gap);
        wait_done(0);
    endtask

    task refuse(input [3:0] m, input [2:0] s);
        seq.issue(m, s, 3'h1, 0);
        check("illegal", {15'h0, illegal}, 16'h0001);
        check("busy", {15'h0, busy}, 16'h0000);
    endtask

    task sc_single;
        exec(4'h0, 3'h1, 3'h1, 0);
        exec(4'h0, 3'h2, 3'h2, 0);
        exec(4'h0, 3'h4, 3'h2, 0);
        exec(4'h0, 3'h4, 3'h3, 0);
        exec(4'h0, 3'h5, 3'h1, 0);
        exec(4'h0, 3'h3, 3'h4, 0);
        exec(4'h0, 3'h1, 3'h4, 0);
    endtask

    task sc_arith;
        exec(4'h0, 3'h2, 3'h5, 0);
        exec(4'h1, 3'h4, 3'h5, 0);
        exec(4'h3, 3'h1, 3'h5, 0);
        exec(4'h4, 3'h5, 3'h1, 1);
        exec(4'h5, 3'h1, 3'h5, 0);
        exec(4'h6, 3'h2, 3'h5, 0);
        exec(4'h7, 3'h1, 3'h2, 0);
        exec(4'h7, 3'h5, 3'h5, 0);
    endtask

    task sc_move;
        exec(4'h2, 3'h1, 3'h6, 0);
        exec(4'h2, 3'h6, 3'h6, 0);
        exec(4'h2, 3'h3, 3'h3, 0);
        exec(4'h2, 3'h1, 3'h2, 2);
        exec(4'h2, 3'h2, 3'h7, 0);
    endtask

    task sc_shift;
        integer op;
        for (op = 0; op < 12; op = op + 1)
            exec(4'h1, op[3:1], {op[0], 2'h1}, 0);
        exec(4'h0, 3'h3, 3'h2, 0);
        for (op = 4; op < 12; op = op + 1)
            exec(4'h1, op[3:1], {op[0], 2'h2}, 0);
    endtask

    // A second request during busy must be ignored and leave register 2 untouched
    task sc_busy;
        model(4'h3, 3'h1, 3'h2);
        seq.issue(4'h3, 3'h1, 3'h2, 0);
        seq.issue(4'h7, 3'h2, 3'h2, 0);
        wait_done(2);
        exec(4'h2, 3'h2, 3'h2, 0);
        refuse(4'h8, 3'h1);
        refuse(4'h0, 3'h0);
        refuse(4'h1, 3'h6);
        exec(4'h0, 3'h1, 3'h2, 0);
    endtask

    task complete_run;
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        errors = 0; checked = 0; i_clk = 1'b0; i_srst = 1'b1;
        for (i = 0; i < 8; i = i + 1)
            rf[i] = 16'h0000;
        fs = 1'b0; fz = 1'b0; fc = 1'b0; fv = 1'b0;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_srst = 1'b0;
        sc_single;
        sc_arith;
        sc_move;
        sc_shift;
        sc_busy;
        complete_run;
    end

    // About 50 instructions of at most 12 cycles each; a wide margin beyond that
    initial
    begin
        repeat (4000) @(posedge i_clk);
        errors = errors + 1;
        complete_run;
    end
endmodule
